// *** hw/mcec_map.vh ***
`ifndef MCEC_MAP_VH
`define MCEC_MAP_VH
// register byte addresses
`define MCEC_ADR_ENC_CTRL   8'h00
`define MCEC_ADR_CAP_MODE   8'h04
`define MCEC_ADR_TB_CTRL    8'h08
`define MCEC_ADR_VEL        8'h0C
`define MCEC_ADR_POS        8'h10
`define MCEC_ADR_LIMIT      8'h14
`define MCEC_ADR_FLAGS      8'h18
`define MCEC_ADR_TIMEBASE   8'h1C
// encoder_control fields
`define MCEC_F_VEL_DIS      7
`define MCEC_F_POS_ERR      6
`define MCEC_F_DIR          5
`define MCEC_F_MODE_HI      4
`define MCEC_F_MODE_LO      2
// encoder modes
`define MCEC_EM_OFF         3'h0
`define MCEC_EM_X2_IDX      3'h1
`define MCEC_EM_X2_LIM      3'h2
`define MCEC_EM_X4_IDX      3'h5
`define MCEC_EM_X4_LIM      3'h6
// channel modes
`define MCEC_CM_OFF         4'h0
`define MCEC_CM_EDGE_LO     4'h1
`define MCEC_CM_EDGE_HI     4'h4
`define MCEC_CM_PERIOD      4'h5
`define MCEC_CM_PW_FR       4'h6
`define MCEC_CM_PW_RF       4'h7
`define MCEC_CM_STATE       4'h8
`define MCEC_CM_SET_FALL    4'hE
`define MCEC_CM_SET_RISE    4'hF
// flag bits
`define MCEC_FL_VEL         0
`define MCEC_FL_POS         1
`define MCEC_FL_DIR         2
// reset values
`define MCEC_RST_CTRL       8'h00
`define MCEC_RST_WORD       16'h0000
`endif

// *** hw/mcec_sync.v ***
`timescale 1ns/1ns
// two flop synchroniser, one per bit
module mcec_sync (
  input  wire       clk_i,   // clock
  input  wire       rst_n_i, // reset, active low
  input  wire [2:0] d_i,     // asynchronous inputs
  output wire [2:0] q_o      // synchronised copy
);
  reg [2:0] s1_r; // first stage, read only by second
  reg [2:0] s2_r; // second stage
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gs
      // per-bit double flop
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          s1_r[g] <= 1'b0;
          s2_r[g] <= 1'b0;
        end else begin
          s1_r[g] <= d_i[g];
          s2_r[g] <= s1_r[g];
        end
      end
    end
  endgenerate
  assign q_o = s2_r;
endmodule

// *** hw/mcec_post.v ***
`timescale 1ns/1ns
`include "mcec_map.vh"
// velocity postscaler: one pulse out per 1, 4, 16 or 64 in
module mcec_post (
  input  wire       clk_i,   // clock
  input  wire       rst_n_i, // reset, active low
  input  wire [1:0] sel_i,   // ratio select
  input  wire       en_i,    // velocity enabled
  input  wire       pulse_i, // input velocity pulse
  output wire       pulse_o  // divided pulse
);
  reg  [5:0] cnt_r;   // pulses seen
  reg  [5:0] last;    // terminal count
  wire       hit;     // terminal reached
  // terminal count from select
  always @* begin
    case (sel_i)
      2'h0:    last = 6'h00;
      2'h1:    last = 6'h03;
      2'h2:    last = 6'h0F;
      default: last = 6'h3F;
    endcase
  end
  assign hit = (cnt_r >= last); // R18
  // count input pulses, wrap at terminal
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 6'h00;
    end else if (!en_i) begin
      cnt_r <= 6'h00;
    end else if (pulse_i) begin
      cnt_r <= hit ? 6'h00 : cnt_r + 6'h01;
    end
  end
  // output keeps the input pulse width
  assign pulse_o = en_i & pulse_i & hit; // R19
endmodule

// *** hw/mcec_top.v ***
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "mcec_map.vh"
// Summary of operation
// R01: channel1 codes 1110/1111 trigger falling/rising
// R02: trigger resets time base when bit low
// R03: capture modes reset time base if enabled
// R04: pulse-width start edge always resets time base
// R05: software never enables capture and encoder
// R06: encoder wins, captures disabled
// R07: filters serve only the active function
// R08: buffers remap to velocity, position, limit
// R09: mode field decodes x2/x4, index/limit
// R10: x2 counts A edges, x4 both
// R11: sixteen bit up/down position counter
// R12: reset on limit or index, flag
// R13: direction bit read only, 1 forward
// R14: direction change sets flag
// R15: error flag sticky on overflow/underflow
// R16: error only in index modes
// R17: bit 7 high disables velocity
// R18: postscale select 1,4,16,64
// R19: postscaler keeps input pulse width
// R20: phase inputs make count, direction, velocity
// R21: position flag ch2, velocity flag ch1
// R22: counter kept across mode changes
// R23: inputs synchronised before edge detect
// R24: writable control bits reset to zero
module mcec_top (
  input  wire        CLOCK_I,       // 50 MHz clock
  input  wire        RESETN_I,      // async reset, active low
  input  wire        WB_CYC_I,      // wishbone cycle
  input  wire        WB_STB_I,      // wishbone strobe
  input  wire        WB_WE_I,       // write enable
  input  wire [7:0]  WB_ADR_I,      // byte address
  input  wire [3:0]  WB_SEL_I,      // byte lanes
  input  wire [31:0] WB_DAT_I,      // write data
  output reg  [31:0] WB_DAT_O,      // read data
  output reg         WB_ACK_O,      // acknowledge
  input  wire        PHASE_A_I,     // encoder phase A / capture in 1
  input  wire        PHASE_B_I,     // encoder phase B / capture in 2
  input  wire        INDEX_I,       // encoder index / capture in 3
  output reg         TRIGGER_O,     // special event trigger pulse
  output reg         TB_RESET_O,    // time base reset pulse
  output reg  [2:0]  FILTER_ENC_O,  // filters routed to encoder
  output reg  [2:0]  FILTER_CAP_O,  // filters routed to capture
  output reg  [2:0]  CAP_EDGE_O,    // capture events per channel
  output reg         VEL_PULSE_O,   // postscaled velocity pulse
  output reg  [2:0]  FLAGS_O        // velocity, position, direction flags
);
  reg        rs1_r;          // reset release stage 1
  reg        rs2_r;          // reset release stage 2
  wire       rst_n;          // synchronous-release reset
  wire [2:0] in_s;           // synchronised pins
  reg  [2:0] in_d_r;         // delayed pins
  reg  [7:0] ctrl_r;         // encoder_control writable bits
  reg        err_r;          // position_error flag
  reg        dir_r;          // direction status
  reg  [11:0] cmode_r;       // chan_mode_sel, 4 bits each
  reg  [2:0] cren_r;         // capture_timer_reset_en per channel
  reg        trig_dis_n_r;   // trigger_reset_disable_n
  reg  [15:0] pos_r;         // position_count
  reg  [15:0] lim_r;         // position_limit
  reg  [15:0] vel_r;         // velocity_result
  reg  [15:0] tb_r;          // capture_time_base
  reg  [2:0] flag_r;         // peripheral flags
  reg  [2:0] pw_arm_r;       // pulse-width start seen per channel
  wire [2:0] rise;           // rising edges
  wire [2:0] fall;           // falling edges
  wire [2:0] emode;          // encoder mode
  wire       enc_on;         // encoder enabled
  wire       x4;             // x4 mode
  wire       idx_mode;       // index reset mode
  wire       cnt_a;          // count on A edge
  wire       cnt_b;          // count on B edge
  wire       cnt_ev;         // count pulse
  wire       up;             // count direction
  wire       fwd_idx;        // forward index reset
  wire       rev_idx;        // reverse index reload
  wire       lim_hit;        // forward limit match
  wire       zero_hit;       // reverse zero reload
  wire       pos_rst;        // counter reset event
  wire       ovf;            // overflow or underflow
  wire       vel_en;         // velocity enabled
  wire       vel_out;        // postscaler output
  wire       bus_req;        // bus request pending
  wire       wr;             // write strobe this cycle
  reg  [2:0] cap_ev;         // capture events
  reg  [2:0] cap_tbr;        // per-channel time base reset
  reg        trig;           // trigger this cycle
  reg  [31:0] rd_nxt;        // read mux
  reg  [15:0] pos_nxt;       // counter next value
  integer    i;              // channel loop index
  integer    j;              // flag loop index, kept apart from the decode loop

  // reset released through two flops
  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rs1_r <= 1'b0;
      rs2_r <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rs2_r <= rs1_r;
    end
  end
  assign rst_n = rs2_r;

  // pin synchroniser
  mcec_sync u_sync (
    .clk_i   (CLOCK_I),
    .rst_n_i (rst_n),
    .d_i     ({INDEX_I, PHASE_B_I, PHASE_A_I}),
    .q_o     (in_s)
  ); // R23

  // edge detection on synchronised pins
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      in_d_r <= 3'h0;
    end else begin
      in_d_r <= in_s;
    end
  end
  assign rise = in_s & ~in_d_r;
  assign fall = ~in_s & in_d_r;

  // mode decode
  assign emode    = ctrl_r[`MCEC_F_MODE_HI:`MCEC_F_MODE_LO];
  assign enc_on   = (emode == `MCEC_EM_X2_IDX) | (emode == `MCEC_EM_X2_LIM) |
                    (emode == `MCEC_EM_X4_IDX) | (emode == `MCEC_EM_X4_LIM); // R09
  assign x4       = enc_on & emode[2]; // R09
  assign idx_mode = enc_on & (emode[1:0] == 2'h1); // R09
  assign vel_en   = enc_on & ~ctrl_r[`MCEC_F_VEL_DIS]; // R17

  // count pulses and direction from phase relation
  assign cnt_a  = enc_on & (rise[0] | fall[0]); // R10
  assign cnt_b  = x4 & (rise[1] | fall[1]); // R10
  assign cnt_ev = cnt_a | cnt_b; // R20
  assign up     = cnt_a ? (in_s[0] ^ in_s[1]) : ~(in_s[0] ^ in_s[1]); // R20

  // reset sources
  assign fwd_idx  = idx_mode & cnt_ev & up & in_s[2];
  assign rev_idx  = idx_mode & cnt_ev & ~up & ~in_s[2];
  assign lim_hit  = enc_on & ~idx_mode & cnt_ev & up & (pos_r == lim_r);
  assign zero_hit = enc_on & ~idx_mode & cnt_ev & ~up & (pos_r == `MCEC_RST_WORD);
  assign pos_rst  = fwd_idx | rev_idx | lim_hit | zero_hit; // R12
  assign ovf      = idx_mode & cnt_ev & ~pos_rst &
                    ((up & (pos_r == 16'hFFFF)) | (~up & (pos_r == 16'h0000))); // R16

  // counter next value
  always @* begin
    pos_nxt = pos_r; // R22
    if (fwd_idx | lim_hit) begin
      pos_nxt = `MCEC_RST_WORD; // R12
    end else if (rev_idx | zero_hit) begin
      pos_nxt = lim_r; // R12
    end else if (cnt_ev) begin
      pos_nxt = up ? pos_r + 16'h0001 : pos_r - 16'h0001; // R11
    end
  end

  // capture side, gated off while encoder runs
  always @* begin
    cap_ev  = 3'h0;
    cap_tbr = 3'h0;
    trig    = 1'b0;
    for (i = 0; i < 3; i = i + 1) begin
      if (!enc_on) begin // R06
        case (cmode_r[i*4 +: 4])
          `MCEC_CM_EDGE_LO, 4'h2, 4'h3, `MCEC_CM_EDGE_HI, `MCEC_CM_PERIOD: begin
            cap_ev[i]  = rise[i] | (cmode_r[i*4 +: 4] == 4'h2 ? fall[i] : 1'b0);
            cap_tbr[i] = cap_ev[i] & cren_r[i]; // R03
          end
          `MCEC_CM_STATE: begin
            cap_ev[i]  = rise[i] | fall[i];
            cap_tbr[i] = cap_ev[i] & cren_r[i]; // R03
          end
          `MCEC_CM_PW_FR: begin
            cap_ev[i]  = rise[i] | fall[i];
            cap_tbr[i] = fall[i]; // R04
          end
          `MCEC_CM_PW_RF: begin
            cap_ev[i]  = rise[i] | fall[i];
            cap_tbr[i] = rise[i]; // R04
          end
          `MCEC_CM_SET_FALL: begin
            if (i == 0) trig = fall[0]; // R01
          end
          `MCEC_CM_SET_RISE: begin
            if (i == 0) trig = rise[0]; // R01
          end
          default: begin
            cap_ev[i] = 1'b0;
          end
        endcase
      end
    end
  end

  // postscaler on velocity pulses (phase A count events)
  mcec_post u_post (
    .clk_i   (CLOCK_I),
    .rst_n_i (rst_n),
    .sel_i   (ctrl_r[1:0]),
    .en_i    (vel_en),
    .pulse_i (cnt_a),
    .pulse_o (vel_out)
  ); // R20

  // wishbone decode: ack one cycle after request
  assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  // write lands on the edge where the master samples ack high, never earlier
  assign wr      = WB_CYC_I & WB_STB_I & WB_WE_I & WB_ACK_O;

  // read mux; buffers remapped in encoder mode
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (WB_ADR_I)
      `MCEC_ADR_ENC_CTRL: rd_nxt = {24'h00_0000, ctrl_r[7], err_r, dir_r, ctrl_r[4:0]};
      `MCEC_ADR_CAP_MODE: rd_nxt = {17'h0_0000, cren_r, cmode_r};
      `MCEC_ADR_TB_CTRL:  rd_nxt = {31'h0000_0000, trig_dis_n_r};
      `MCEC_ADR_VEL:      rd_nxt = {16'h0000, vel_r}; // R08
      `MCEC_ADR_POS:      rd_nxt = {16'h0000, pos_r}; // R08
      `MCEC_ADR_LIMIT:    rd_nxt = {16'h0000, lim_r}; // R08
      `MCEC_ADR_FLAGS:    rd_nxt = {29'h0000_0000, flag_r};
      `MCEC_ADR_TIMEBASE: rd_nxt = {16'h0000, tb_r};
      default:            rd_nxt = 32'h0000_0000;
    endcase
  end

  // bus response
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req ? rd_nxt : 32'h0000_0000;
    end
  end

  // control and configuration registers
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r       <= `MCEC_RST_CTRL; // R24
      cmode_r      <= 12'h000;
      cren_r       <= 3'h0;
      trig_dis_n_r <= 1'b0;
      lim_r        <= `MCEC_RST_WORD;
    end else if (wr && WB_SEL_I[0]) begin
      case (WB_ADR_I)
        `MCEC_ADR_ENC_CTRL: ctrl_r <= {WB_DAT_I[7], 2'h0, WB_DAT_I[4:0]}; // R13
        `MCEC_ADR_CAP_MODE: begin
          cmode_r[7:0] <= WB_DAT_I[7:0];
          if (WB_SEL_I[1]) begin
            cmode_r[11:8] <= WB_DAT_I[11:8];
            cren_r        <= WB_DAT_I[14:12];
          end
        end
        `MCEC_ADR_TB_CTRL:  trig_dis_n_r <= WB_DAT_I[0];
        `MCEC_ADR_LIMIT:    lim_r <= {WB_SEL_I[1] ? WB_DAT_I[15:8] : lim_r[15:8],
                                      WB_DAT_I[7:0]};
        default:            lim_r <= lim_r;
      endcase
    end
  end

  // position counter, direction, error flag
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      pos_r <= `MCEC_RST_WORD;
      dir_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wr && WB_ADR_I == `MCEC_ADR_POS && WB_SEL_I[0]) begin
        pos_r <= {WB_SEL_I[1] ? WB_DAT_I[15:8] : pos_r[15:8], WB_DAT_I[7:0]};
      end else begin
        pos_r <= pos_nxt; // R11
      end
      if (cnt_ev) begin
        dir_r <= up; // R13
      end
      if (ovf) begin
        err_r <= 1'b1; // R15
      end else if (wr && WB_ADR_I == `MCEC_ADR_ENC_CTRL && WB_SEL_I[0] &&
                   !WB_DAT_I[`MCEC_F_POS_ERR]) begin
        err_r <= 1'b0; // R15
      end
    end
  end

  // velocity result counts clock cycles between postscaled outputs
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      vel_r <= `MCEC_RST_WORD;
    end else if (vel_out) begin
      vel_r <= `MCEC_RST_WORD;
    end else if (vel_en) begin
      vel_r <= vel_r + 16'h0001;
    end
  end

  // time base: free running, reset by trigger or capture
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      tb_r <= `MCEC_RST_WORD;
    end else if ((trig & ~trig_dis_n_r) | (|cap_tbr)) begin
      tb_r <= `MCEC_RST_WORD; // R02
    end else begin
      tb_r <= tb_r + 16'h0001;
    end
  end

  // sticky flags: set wins over software write-one clear
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 3'h0;
    end else begin
      for (j = 0; j < 3; j = j + 1) begin
        if ((j == `MCEC_FL_VEL && (enc_on ? vel_out : cap_ev[0])) || // R21
            (j == `MCEC_FL_POS && (enc_on ? pos_rst : cap_ev[1])) || // R12
            (j == `MCEC_FL_DIR && (enc_on ? (cnt_ev && up != dir_r) : cap_ev[2]))) begin // R14
          flag_r[j] <= 1'b1;
        end else if (wr && WB_ADR_I == `MCEC_ADR_FLAGS && WB_SEL_I[0] && WB_DAT_I[j]) begin
          flag_r[j] <= 1'b0;
        end
      end
    end
  end

  // registered outputs
  always @(posedge CLOCK_I or negedge rst_n) begin
    if (!rst_n) begin
      TRIGGER_O    <= 1'b0;
      TB_RESET_O   <= 1'b0;
      FILTER_ENC_O <= 3'h0;
      FILTER_CAP_O <= 3'h0;
      CAP_EDGE_O   <= 3'h0;
      VEL_PULSE_O  <= 1'b0;
      FLAGS_O      <= 3'h0;
    end else begin
      TRIGGER_O    <= trig; // R01
      TB_RESET_O   <= (trig & ~trig_dis_n_r) | (|cap_tbr); // R02
      FILTER_ENC_O <= enc_on ? 3'h7 : 3'h0; // R07
      FILTER_CAP_O <= enc_on ? 3'h0 : 3'h7; // R07
      CAP_EDGE_O   <= cap_ev;
      VEL_PULSE_O  <= vel_out; // R19
      FLAGS_O      <= flag_r;
    end
  end
endmodule

// *** verif/mcec_asserts.sv ***
`timescale 1ns/1ns
// port checker for the encoder and capture block
module mcec_asserts (
  input wire        CLOCK_I,      // clock
  input wire        RESETN_I,     // reset, active low
  input wire        WB_CYC_I,     // bus cycle
  input wire        WB_STB_I,     // bus strobe
  input wire        WB_WE_I,      // bus write
  input wire [7:0]  WB_ADR_I,     // bus address
  input wire [31:0] WB_DAT_O,     // read data
  input wire        WB_ACK_O,     // acknowledge
  input wire        PHASE_A_I,    // phase A pin
  input wire        TRIGGER_O,    // trigger pulse
  input wire        TB_RESET_O,   // time base reset pulse
  input wire [2:0]  FILTER_ENC_O, // filters on encoder
  input wire [2:0]  FILTER_CAP_O, // filters on capture
  input wire [2:0]  CAP_EDGE_O,   // capture events
  input wire        VEL_PULSE_O,  // velocity pulse
  input wire [2:0]  FLAGS_O       // event flags
);
  reg  [3:0] since_a_r; // clocks since phase A moved, saturating
  reg        a_q_r;     // previous phase A sample
  wire       flag_wr;   // write to the flag register
  assign flag_wr = WB_CYC_I && WB_STB_I && WB_WE_I && (WB_ADR_I == 8'h18);
  // age of the last phase A change, so a trigger can be tied to it
  always @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      since_a_r <= 4'h0;
      a_q_r     <= 1'b0;
    end else begin
      a_q_r     <= PHASE_A_I;
      since_a_r <= (PHASE_A_I != a_q_r) ? 4'h0 : since_a_r + {3'h0, since_a_r != 4'hf};
    end
  end
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_ans;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence
  a_ack_once: assert property (s_req |=> s_ans)
    else $error("bus answer not a single pulse one cycle after request");
  a_dat_quiet: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0000_0000)
    else $error("read data not zero outside acknowledge");
  a_filter_excl: assert property (!((|FILTER_ENC_O) && (|FILTER_CAP_O)))
    else $error("filters serve both functions");
  a_enc_first: assert property ((|FILTER_ENC_O) |-> CAP_EDGE_O == 3'h0)
    else $error("capture event while encoder owns the pins");
  a_trig_pulse: assert property (TRIGGER_O |=> !TRIGGER_O)
    else $error("trigger longer than one cycle");
  a_trig_cause: assert property (TRIGGER_O |-> since_a_r >= 4'h2 && since_a_r <= 4'h7)
    else $error("trigger without a recent phase A edge");
  a_vel_width: assert property (VEL_PULSE_O |=> !VEL_PULSE_O)
    else $error("velocity pulse wider than input pulse");
  a_tbr_pulse: assert property (TB_RESET_O |=> !TB_RESET_O)
    else $error("time base reset longer than one cycle");
  a_flag_hold: assert property ((|($past(FLAGS_O) & ~FLAGS_O)) |->
    $past(flag_wr, 1) || $past(flag_wr, 2) || $past(flag_wr, 3))
    else $error("flag cleared without a flag write");
endmodule

// *** verif/mcec_enc_model.sv ***
`timescale 1ns/1ns
// incremental encoder: gray steps on the phases, index level on demand
module mcec_enc_model (
  input  wire clk_i, // bench clock
  output reg  pha_o, // phase A
  output reg  phb_o, // phase B
  output reg  idx_o  // index
);
  // pins start low
  initial begin
    pha_o = 1'b0;
    phb_o = 1'b0;
    idx_o = 1'b0;
  end
  // one pin change per step; forward keeps A leading B
  task step(input fwd);
    begin
      @(posedge clk_i);
      if ((pha_o == phb_o) == fwd) pha_o <= ~pha_o;
      else phb_o <= ~phb_o;
      // four clocks between pin changes, well above the sync delay
      repeat (3) @(posedge clk_i);
    end
  endtask
  // index level, changed just after an edge
  task set_index(input v);
    begin
      @(posedge clk_i);
      idx_o <= v;
    end
  endtask
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
// bench: register rows, event rows, then encoder scenarios
module tb;
  reg         clk, rst_n;             // clock, reset active low
  reg         cyc, stb, we;           // bus request
  reg  [7:0]  adr;                    // bus address
  reg  [3:0]  sel;                    // byte lanes
  reg  [31:0] wdat, q;                // write data, last read
  wire [31:0] rdat;                   // read data
  wire        ack, trig, tbr, vel;    // design answers
  wire        pa, pb, ix;             // encoder pins
  wire [2:0]  fenc, fcap, cape, flags;
  integer     miscompares, tests_run, cycles, i, k, t0, t1, t2;
  integer     trig_n, tbr_n, cap_n, vel_n; // event counts
  reg  [39:0] rrow;                   // address, write, expected read
  reg  [63:0] erow;                   // event row
  reg  [39:0] regs [0:5];
  reg  [63:0] evts [0:6];
  mcec_top uut (.CLOCK_I(clk), .RESETN_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .PHASE_A_I(pa), .PHASE_B_I(pb), .INDEX_I(ix), .TRIGGER_O(trig),
    .TB_RESET_O(tbr), .FILTER_ENC_O(fenc), .FILTER_CAP_O(fcap), .CAP_EDGE_O(cape),
    .VEL_PULSE_O(vel), .FLAGS_O(flags));
  mcec_enc_model enc (.clk_i(clk), .pha_o(pa), .phb_o(pb), .idx_o(ix));
  // clock at 50 MHz
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // event counters and hang guard
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (trig === 1'b1) trig_n = trig_n + 1;
    if (tbr === 1'b1) tbr_n = tbr_n + 1;
    if (cape[0] === 1'b1) cap_n = cap_n + 1;
    if (vel === 1'b1) vel_n = vel_n + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // classic single cycle, held until ack is sampled high
  task wb(input [7:0] a, input w, input [15:0] d);
    begin
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {16'h0000, d};
      @(posedge clk);
      while (ack !== 1'b1) @(posedge clk);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task rc(input [7:0] a, input [15:0] e, input string nm);
    begin
      wb(a, 1'b0, 16'h0000);
      chk(nm, q, {16'h0000, e});
    end
  endtask
  task steps(input integer n, input fwd);
    begin
      for (k = 0; k < n; k = k + 1) enc.step(fwd);
      repeat (6) @(posedge clk);
    end
  endtask
  initial begin
    regs[0] = 40'h00_00ff_009f; // unused mode, direction and error not writable
    regs[1] = 40'h14_1234_1234;
    regs[2] = 40'h10_abcd_abcd;
    regs[3] = 40'h24_ffff_0000; // unmapped
    regs[4] = 40'h08_0001_0001;
    regs[5] = 40'h04_7fff_7fff;
    // capture modes, timer ctrl, encoder ctrl, triggers, tb resets, captures
    evts[0] = 64'h000e_0000_0101_ff00;
    evts[1] = 64'h000f_0100_0100_ff00;
    evts[2] = 64'h000f_0000_0101_ff00;
    evts[3] = 64'h1008_0000_0002_0200;
    evts[4] = 64'h0008_0000_0000_0200;
    evts[5] = 64'h0006_0000_0001_ff00;
    evts[6] = 64'h1008_0004_0000_0000;
    {rst_n, cyc, stb, we, adr, sel, wdat} = 0;
    sel = 4'h3;
    {miscompares, tests_run, cycles, trig_n, tbr_n, cap_n, vel_n} = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (i = 0; i < 7; i = i + 1) rc(8'(i * 4), 16'h0000, "reset value");
    for (i = 0; i < 6; i = i + 1) begin
      rrow = regs[i];
      wb(rrow[39:32], 1'b1, rrow[31:16]);
      rc(rrow[39:32], rrow[15:0], "register");
    end
    for (i = 0; i < 7; i = i + 1) begin
      erow = evts[i];
      wb(8'h00, 1'b1, 16'h0000);
      wb(8'h04, 1'b1, erow[63:48]);
      wb(8'h08, 1'b1, {8'h00, erow[47:40]});
      wb(8'h00, 1'b1, {8'h00, erow[39:32]});
      {t0, t1, t2} = {trig_n, tbr_n, cap_n};
      steps(4, 1'b1);
      chk("triggers", trig_n - t0, {24'h00_0000, erow[31:24]});
      chk("tb resets", tbr_n - t1, {24'h00_0000, erow[23:16]});
      if (erow[15:8] != 8'hff) chk("captures", cap_n - t2, {24'h00_0000, erow[15:8]});
      chk("filters", 32'(fenc), (erow[39:32] != 0) ? 32'h0000_0007 : 32'h0000_0000);
      chk("cap filters", 32'(fcap), (erow[39:32] != 0) ? 32'h0000_0000 : 32'h0000_0007);
    end
    wb(8'h04, 1'b1, 16'h0000);
    // x4 limit mode: wrap at the limit and at zero
    wb(8'h14, 1'b1, 16'h0005);
    wb(8'h10, 1'b1, 16'h0003);
    wb(8'h00, 1'b1, 16'h0018);
    steps(4, 1'b1);
    rc(8'h10, 16'h0001, "x4 forward");
    rc(8'h00, 16'h0038, "forward dir");
    chk("pos flag", 32'(flags[1]), 32'h0000_0001);
    wb(8'h18, 1'b1, 16'h0007);
    steps(3, 1'b0);
    rc(8'h10, 16'h0004, "x4 reverse");
    rc(8'h00, 16'h0018, "reverse dir");
    chk("dir flag", 32'(flags[2]), 32'h0000_0001);
    chk("pos flag", 32'(flags[1]), 32'h0000_0001);
    wb(8'h00, 1'b1, 16'h0004);
    rc(8'h10, 16'h0004, "mode change");
    wb(8'h00, 1'b1, 16'h0000);
    rc(8'h10, 16'h0004, "encoder off");
    // x2 index mode: only A edges count, rollover sets the error
    wb(8'h10, 1'b1, 16'hfffe);
    wb(8'h00, 1'b1, 16'h0004);
    steps(4, 1'b1);
    rc(8'h10, 16'h0000, "x2 rollover");
    rc(8'h00, 16'h0064, "error set");
    wb(8'h00, 1'b1, 16'h0044);
    rc(8'h00, 16'h0064, "error kept");
    wb(8'h00, 1'b1, 16'h0004);
    rc(8'h00, 16'h0024, "error cleared");
    // index high on a forward count edge clears the count
    wb(8'h10, 1'b1, 16'h0007);
    wb(8'h18, 1'b1, 16'h0007);
    enc.set_index(1'b1);
    steps(2, 1'b1);
    enc.set_index(1'b0);
    rc(8'h10, 16'h0000, "index reset");
    chk("index flag", 32'(flags[1]), 32'h0000_0001);
    // postscaler: one pulse per ratio of A edges, every code
    for (i = 0; i < 4; i = i + 1) begin
      wb(8'h00, 1'b1, 16'h0004 | 16'(i));
      t0 = vel_n;
      steps(2 << (2 * i), 1'b1);
      chk("postscale", vel_n - t0, 32'h0000_0001);
    end
    chk("vel flag", 32'(flags[0]), 32'h0000_0001);
    wb(8'h00, 1'b1, 16'h0084);
    t0 = vel_n;
    steps(4, 1'b1);
    chk("vel disabled", vel_n - t0, 32'h0000_0000);
    // second reset in mid-run: flags and control must come back cleared
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk("flags after reset", 32'(flags), 32'h0000_0000);
    rc(8'h00, 16'h0000, "ctrl after reset");
    stop_test;
  end
endmodule
bind mcec_top mcec_asserts chk_u (
  .CLOCK_I      (CLOCK_I),
  .RESETN_I     (RESETN_I),
  .WB_CYC_I     (WB_CYC_I),
  .WB_STB_I     (WB_STB_I),
  .WB_WE_I      (WB_WE_I),
  .WB_ADR_I     (WB_ADR_I),
  .WB_DAT_O     (WB_DAT_O),
  .WB_ACK_O     (WB_ACK_O),
  .PHASE_A_I    (PHASE_A_I),
  .TRIGGER_O    (TRIGGER_O),
  .TB_RESET_O   (TB_RESET_O),
  .FILTER_ENC_O (FILTER_ENC_O),
  .FILTER_CAP_O (FILTER_CAP_O),
  .CAP_EDGE_O   (CAP_EDGE_O),
  .VEL_PULSE_O  (VEL_PULSE_O),
  .FLAGS_O      (FLAGS_O)
);
